// *** rtl/partition_auto_arm_scheduler.sv ***
// Partition auto-arm/disarm scheduler with Wishbone register access
`timescale 1ns/100ps
`default_nettype none
module partition_auto_arm_scheduler #(
  parameter int unsigned TICK_CYCLES = sched_pkg::TICK_CYCLES,
  parameter int unsigned HOUR_S = sched_pkg::EXT_HOUR_S
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Schedule windows and partition state
  input wire logic open_win_i,
  input wire logic close_win_i,
  input wire logic [19:0] win_active_i,
  input wire logic [19:0] timer_due_i,
  input wire logic armed_i,
  input wire logic in_alarm_i,
  input wire logic faults_i,
  // Keypad requests
  input wire logic ext_req_i,
  input wire logic ext_two_i,
  input wire logic disarm_req_i,
  input wire logic code_req_i,
  input wire logic [2:0] code_sched_i,
  input wire logic code_sched_en_i,
  input wire logic sched_holiday_i,
  // Actions and keypad indications
  output logic full_perimeter_arm_mode_o,
  output logic bypass_faults_o,
  output logic disarm_o,
  output logic disarm_ok_o,
  output logic beep_o,
  output logic alert_msg_o,
  output logic schedule_reject_message_o,
  output logic code_ok_o,
  output logic open_report_o,
  output logic close_report_o,
  output logic missed_open_o,
  output logic missed_close_o,
  output logic relay_o,
  output logic [19:0] timer_out_o
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned SW = 14;

  logic [31:0] ctrl;
  logic [31:0] delays;
  logic [31:0] access_map;
  logic [19:0] timer_en;
  logic [19:0] timer_once;
  logic [TW-1:0] tick_cnt;
  logic tick;
  sched_pkg::arm_state_t state;
  logic [SW-1:0] secs;
  logic [SW-1:0] ext_secs;
  logic [SW-1:0] dis_secs;
  logic dis_run;
  logic [3:0] beep_cnt;
  logic close_d;
  logic open_d;
  logic armed_d;
  logic win_d;
  logic relay_done;
  logic [19:0] timer_done;

  // Converts a step count to seconds; steps cap at fourteen
  function automatic logic [SW-1:0] step_secs(input logic [3:0] steps);
    logic [3:0] s;
    s = (steps > 4'(sched_pkg::MAX_STEP)) ? 4'(sched_pkg::MAX_STEP) : steps;
    step_secs = SW'(s) * SW'(sched_pkg::STEP_MIN * 60);
  endfunction

  // Field decode
  wire logic [3:0] grace_steps = delays[3:0];
  wire logic [3:0] warn_raw = delays[11:8];
  wire logic [3:0] dis_steps = delays[19:16];
  wire logic [3:0] warn_min = (warn_raw == 4'h0) ? 4'h1 : warn_raw;
  wire logic [SW-1:0] warn_secs = SW'(warn_min) * SW'(60);
  wire logic [1:0] rmode = ctrl[sched_pkg::C_RMODE +: 2];
  wire logic once = ctrl[sched_pkg::C_ONCE];
  wire logic close_end = close_d & ~close_win_i;
  wire logic open_end = open_d & ~open_win_i;
  wire logic win_rise = win_active_i[0] & ~win_d;
  wire logic win_fall = ~win_active_i[0] & win_d;
  wire logic arm_edge = armed_i & ~armed_d;
  wire logic dis_edge = ~armed_i & armed_d;
  wire logic bus_req = cyc_i & stb_i & ~ack_o;
  wire logic bus_wr = bus_req & we_i;
  wire logic ext_fire = bus_wr && adr_i == sched_pkg::ADR_CMD && sel_i[0] && dat_i[0];
  wire logic ext_any = ext_req_i | ext_fire;
  // Only a command write may pick the length from the bus data
  wire logic ext_long = ext_fire ? dat_i[1] : ext_two_i;
  wire logic [SW-1:0] ext_amt = ext_long ? SW'(2 * HOUR_S) : SW'(HOUR_S);
  wire logic fast = (state == sched_pkg::ST_WARN) && (secs <= SW'(sched_pkg::FAST_WINDOW_S));
  wire logic [3:0] beep_period = fast ? 4'(sched_pkg::BEEP_FAST_S) : 4'(sched_pkg::BEEP_SLOW_S);
  wire logic in_any_win = open_win_i | close_win_i;
  wire logic arm_now = (state == sched_pkg::ST_WARN) && tick && (secs == SW'(1));
  wire logic sched_bit = access_map[{code_sched_i, 2'b00} +: 1] |
    (sched_holiday_i ? access_map[{code_sched_i, 2'b10} +: 1] : access_map[{code_sched_i, 2'b01} +: 1]);
  // Widened index so schedule seven reaches window eight, not window zero
  wire logic code_allowed = ~code_sched_en_i |
    (sched_bit & win_active_i[{2'b00, code_sched_i} + 5'h01]);

  // Shared one-second tick for every countdown
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
    end
  end
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  // Edge history of windows and arming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      close_d <= 1'b0;
      open_d <= 1'b0;
      armed_d <= 1'b0;
      win_d <= 1'b0;
    end else begin
      close_d <= close_win_i;
      open_d <= open_win_i;
      armed_d <= armed_i;
      win_d <= win_active_i[0];
    end
  end

  // Auto-arm sequencer: extension, grace, warning, arm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sched_pkg::ST_IDLE;
      secs <= '0;
      ext_secs <= '0;
    end else begin
      case (state)
        sched_pkg::ST_IDLE: begin
          if (ext_any && (close_win_i || ext_secs != '0)) begin
            ext_secs <= ext_secs + ext_amt;
          end else if (tick && ext_secs != '0 && !close_win_i) begin
            ext_secs <= ext_secs - SW'(1);
            if (ext_secs == SW'(1) && ctrl[sched_pkg::C_AUTOARM] && !armed_i) begin
              state <= sched_pkg::ST_GRACE;
              secs <= step_secs(grace_steps);
            end
          end else if (close_end && ext_secs == '0 && ctrl[sched_pkg::C_AUTOARM] && !armed_i) begin
            state <= sched_pkg::ST_GRACE;
            secs <= step_secs(grace_steps);
          end
        end
        sched_pkg::ST_GRACE: begin
          if (armed_i) begin
            state <= sched_pkg::ST_IDLE;
          end else if (secs == '0 || (tick && secs == SW'(1))) begin
            state <= sched_pkg::ST_WARN;
            secs <= warn_secs;
          end else if (tick) begin
            secs <= secs - SW'(1);
          end
        end
        sched_pkg::ST_WARN: begin
          if (armed_i || arm_now) begin
            state <= sched_pkg::ST_IDLE;
            secs <= '0;
          end else if (tick) begin
            secs <= secs - SW'(1);
          end
        end
        default: state <= sched_pkg::ST_IDLE;
      endcase
    end
  end

  // Beep cadence counted in seconds of warning
  always_ff @(posedge clk_i) begin
    if (rst_i || state != sched_pkg::ST_WARN) begin
      beep_cnt <= '0;
    end else if (tick) begin
      beep_cnt <= (beep_cnt + 4'h1 >= beep_period) ? 4'h0 : beep_cnt + 4'h1;
    end
  end

  // Auto-disarm delay after the opening window closes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_run <= 1'b0;
      dis_secs <= '0;
    end else if (open_end && ctrl[sched_pkg::C_AUTODIS] && armed_i) begin
      dis_run <= 1'b1;
      dis_secs <= step_secs(dis_steps);
    end else if (dis_run && (!armed_i || dis_secs == '0)) begin
      dis_run <= 1'b0;
    end else if (dis_run && tick) begin
      dis_secs <= dis_secs - SW'(1);
    end
  end

  // Relay and user timers, with one-shot lockout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_done <= 1'b0;
      timer_done <= '0;
      timer_out_o <= '0;
    end else begin
      if (win_fall && once) begin
        relay_done <= 1'b1;
      end
      timer_done <= timer_done | (timer_due_i & timer_once);
      timer_out_o <= timer_due_i & timer_en & ~timer_done;
    end
  end

  // Actions and keypad indications
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_perimeter_arm_mode_o <= 1'b0;
      bypass_faults_o <= 1'b0;
      disarm_o <= 1'b0;
      disarm_ok_o <= 1'b0;
      beep_o <= 1'b0;
      alert_msg_o <= 1'b0;
      schedule_reject_message_o <= 1'b0;
      code_ok_o <= 1'b0;
      open_report_o <= 1'b0;
      close_report_o <= 1'b0;
      missed_open_o <= 1'b0;
      missed_close_o <= 1'b0;
      relay_o <= 1'b0;
    end else begin
      full_perimeter_arm_mode_o <= arm_now;
      bypass_faults_o <= arm_now && ctrl[sched_pkg::C_FORCE] && faults_i;
      disarm_o <= dis_run && armed_i && (dis_secs == '0);
      disarm_ok_o <= disarm_req_i && (!ctrl[sched_pkg::C_RESTRICT] || in_any_win
        || (ctrl[sched_pkg::C_OVERRIDE] && in_alarm_i));
      beep_o <= (state == sched_pkg::ST_WARN) && tick && (beep_cnt == 4'h0);
      alert_msg_o <= (state == sched_pkg::ST_WARN);
      schedule_reject_message_o <= code_req_i && !code_allowed;
      code_ok_o <= code_req_i && code_allowed;
      open_report_o <= dis_edge && (!ctrl[sched_pkg::C_EXCEPT] || !in_any_win);
      close_report_o <= arm_edge && (!ctrl[sched_pkg::C_EXCEPT] || !close_win_i);
      missed_open_o <= open_end && ctrl[sched_pkg::C_MISSED] && armed_i;
      missed_close_o <= close_end && ext_secs == '0 && ctrl[sched_pkg::C_MISSED] && !armed_i;
      case (rmode)
        sched_pkg::RM_START: relay_o <= relay_done ? relay_o : (relay_o | win_rise);
        sched_pkg::RM_END: relay_o <= relay_done ? relay_o : (relay_o | win_fall);
        sched_pkg::RM_DURING: relay_o <= win_active_i[0] & ~relay_done;
        sched_pkg::RM_BOTH: relay_o <= (win_rise | win_fall) & ~relay_done;
        default: relay_o <= 1'b0;
      endcase
    end
  end

  // Wishbone registers, single registered answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
      ctrl <= sched_pkg::CTRL_RESET;
      delays <= sched_pkg::DELAYS_RESET;
      access_map <= '0;
      timer_en <= '0;
      timer_once <= '0;
    end else begin
      ack_o <= bus_req;
      if (bus_wr && sel_i[0]) begin
        case (adr_i)
          sched_pkg::ADR_CTRL: ctrl[7:0] <= dat_i[7:0];
          sched_pkg::ADR_DELAYS: delays[7:0] <= dat_i[7:0];
          sched_pkg::ADR_ACCESS: access_map[7:0] <= dat_i[7:0];
          sched_pkg::ADR_TIMERS: timer_en[7:0] <= dat_i[7:0];
          sched_pkg::ADR_RELAY: timer_once[7:0] <= dat_i[7:0];
          default: ;
        endcase
      end
      if (bus_wr && sel_i[1]) begin
        case (adr_i)
          sched_pkg::ADR_CTRL: ctrl[15:8] <= dat_i[15:8];
          sched_pkg::ADR_DELAYS: delays[15:8] <= dat_i[15:8];
          sched_pkg::ADR_ACCESS: access_map[15:8] <= dat_i[15:8];
          sched_pkg::ADR_TIMERS: timer_en[15:8] <= dat_i[15:8];
          sched_pkg::ADR_RELAY: timer_once[15:8] <= dat_i[15:8];
          default: ;
        endcase
      end
      if (bus_wr && sel_i[2]) begin
        case (adr_i)
          sched_pkg::ADR_DELAYS: delays[23:16] <= dat_i[23:16];
          sched_pkg::ADR_ACCESS: access_map[23:16] <= dat_i[23:16];
          sched_pkg::ADR_TIMERS: timer_en[19:16] <= dat_i[19:16];
          sched_pkg::ADR_RELAY: timer_once[19:16] <= dat_i[19:16];
          default: ;
        endcase
      end
      if (bus_wr && sel_i[3] && adr_i == sched_pkg::ADR_ACCESS) begin
        access_map[31:24] <= dat_i[31:24];
      end
      case (adr_i)
        sched_pkg::ADR_CTRL: dat_o <= {22'h0, ctrl[9:0]};
        sched_pkg::ADR_DELAYS: dat_o <= {12'h0, delays[19:16], 4'h0, delays[11:8], 4'h0, delays[3:0]};
        sched_pkg::ADR_STATUS: dat_o <= {2'h0, secs, ext_secs[13:2], 1'b0, dis_run,
          state == sched_pkg::ST_WARN, state == sched_pkg::ST_GRACE};
        sched_pkg::ADR_ACCESS: dat_o <= access_map;
        sched_pkg::ADR_TIMERS: dat_o <= {12'h0, timer_en};
        sched_pkg::ADR_RELAY: dat_o <= {12'h0, timer_once};
        default: dat_o <= '0;
      endcase
    end
  end

  // Arming follows the warning end by one edge
  a_arm_follows_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    arm_now |=> full_perimeter_arm_mode_o) else $error("arm pulse missing");
  a_arm_only_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    full_perimeter_arm_mode_o |-> $past(state) == sched_pkg::ST_WARN) else $error("arm outside warning");
  a_grace_to_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == sched_pkg::ST_GRACE && !armed_i && secs == '0) |=> state == sched_pkg::ST_WARN)
    else $error("grace did not end");
  a_warn_length: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == sched_pkg::ST_GRACE ##1 state == sched_pkg::ST_WARN) |-> secs == warn_secs)
    else $error("bad warning length");
  a_grace_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    state == sched_pkg::ST_GRACE |-> secs <= SW'(56 * 60)) else $error("grace too long");
  a_alert_in_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    alert_msg_o |-> $past(state) == sched_pkg::ST_WARN) else $error("alert outside warning");
  a_restrict_disarm: assert property (@(posedge clk_i) disable iff (rst_i)
    (disarm_req_i && ctrl[sched_pkg::C_RESTRICT] && !in_any_win && !in_alarm_i) |=> !disarm_ok_o)
    else $error("restricted disarm accepted");
  a_override_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
    (disarm_req_i && ctrl[sched_pkg::C_OVERRIDE] && in_alarm_i) |=> disarm_ok_o)
    else $error("alarm disarm refused");
  a_reject_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (code_req_i && !code_allowed) |=> schedule_reject_message_o && !code_ok_o)
    else $error("scheduled code not rejected");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  // Bypass, beeps, missed closing reports and timers only follow their causes
  a_bypass_with_arm: assert property (@(posedge clk_i) disable iff (rst_i)
    bypass_faults_o |-> full_perimeter_arm_mode_o) else $error("bypass without arm");
  a_beep_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    beep_o |-> $past(tick)) else $error("beep off the second tick");
  a_missed_unarmed: assert property (@(posedge clk_i) disable iff (rst_i)
    missed_close_o |-> !$past(armed_i)) else $error("missed closing while armed");
  a_timer_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    (timer_out_o & ~$past(timer_en)) == '0) else $error("disabled timer fired");
endmodule // partition_auto_arm_scheduler
`default_nettype wire

// *** rtl/sched_pkg.sv ***
// Shared constants for the partition auto-arm scheduler
package sched_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  localparam int unsigned STEP_MIN = 4;
  localparam int unsigned MAX_STEP = 14;
  localparam int unsigned MAX_WARN_MIN = 15;
  localparam int unsigned BEEP_SLOW_S = 15;
  localparam int unsigned BEEP_FAST_S = 5;
  localparam int unsigned FAST_WINDOW_S = 60;
  localparam int unsigned EXT_HOUR_S = 3600;
  localparam int unsigned NUM_TIMERS = 20;
  localparam int unsigned NUM_ACCESS = 8;
  localparam int unsigned NUM_WIN = 20;
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DELAYS = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_CMD = 8'h0c;
  localparam logic [7:0] ADR_TIMERS = 8'h10;
  localparam logic [7:0] ADR_ACCESS = 8'h14;
  localparam logic [7:0] ADR_RELAY = 8'h18;
  // Control bit positions
  localparam int unsigned C_AUTOARM = 0;
  localparam int unsigned C_AUTODIS = 1;
  localparam int unsigned C_FORCE = 2;
  localparam int unsigned C_RESTRICT = 3;
  localparam int unsigned C_OVERRIDE = 4;
  localparam int unsigned C_EXCEPT = 5;
  localparam int unsigned C_MISSED = 6;
  localparam int unsigned C_ONCE = 7;
  localparam int unsigned C_RMODE = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam logic [31:0] DELAYS_RESET = 32'h0000_0100;
  // Relay modes
  localparam logic [1:0] RM_START = 2'h0;
  localparam logic [1:0] RM_END = 2'h1;
  localparam logic [1:0] RM_DURING = 2'h2;
  localparam logic [1:0] RM_BOTH = 2'h3;
  typedef enum {ST_IDLE, ST_GRACE, ST_WARN} arm_state_t;
endpackage : sched_pkg

// *** verif/partition_partner.sv ***
// Behavioural model of the partition and keypad sounder
`timescale 1ns/100ps
`default_nettype none
module partition_partner (
  // Clock
  input wire logic clk_i,
  // Scheduler actions
  input wire logic arm_i,
  input wire logic disarm_i,
  input wire logic disarm_ok_i,
  input wire logic beep_i,
  // Partition state back to the scheduler
  output logic armed_o,
  output logic [7:0] beeps_o
);
  // Partition latches armed on the arm pulse; no reset, it outlives the panel logic
  initial armed_o = 1'b0;
  initial beeps_o = 8'h00;
  always @(posedge clk_i) begin
    if (arm_i) begin
      armed_o <= 1'b1;
    end else if (disarm_i || disarm_ok_i) begin
      armed_o <= 1'b0;
    end
  end
  // Sounder counts every beep it hears
  always @(posedge clk_i) begin
    if (beep_i) begin
      beeps_o <= beeps_o + 8'h01;
    end
  end
endmodule // partition_partner
`default_nettype wire

// *** verif/partition_auto_arm_scheduler_tb.sv ***
// Self-checking bench for the partition auto-arm scheduler
`timescale 1ns/100ps
`default_nettype none
module partition_auto_arm_scheduler_tb;
  typedef struct {int kind; int gap; int tol; logic [31:0] data;} note_t;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rnd;
  logic open_win_i, close_win_i, armed_i, in_alarm_i, faults_i;
  logic [19:0] win_active_i, timer_due_i, timer_out_o;
  logic ext_req_i, ext_two_i, disarm_req_i, code_req_i, code_sched_en_i, sched_holiday_i;
  logic [2:0] code_sched_i;
  logic full_perimeter_arm_mode_o, bypass_faults_o, disarm_o, disarm_ok_o, beep_o, alert_msg_o;
  logic schedule_reject_message_o, code_ok_o, open_report_o, close_report_o;
  logic missed_open_o, missed_close_o, relay_o, rel_d, dis_d;
  logic [10:0] ev;
  logic [19:0] due_d;
  logic tm_chk, seen1;
  note_t notes[$];
  int err_total, checked, cyc, mark;

  partition_auto_arm_scheduler #(.TICK_CYCLES(20), .HOUR_S(10)) i_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .open_win_i, .close_win_i, .win_active_i, .timer_due_i, .armed_i, .in_alarm_i,
    .faults_i, .ext_req_i, .ext_two_i, .disarm_req_i, .code_req_i, .code_sched_i,
    .code_sched_en_i, .sched_holiday_i, .full_perimeter_arm_mode_o, .bypass_faults_o,
    .disarm_o, .disarm_ok_o, .beep_o, .alert_msg_o, .schedule_reject_message_o,
    .code_ok_o, .open_report_o, .close_report_o, .missed_open_o, .missed_close_o,
    .relay_o, .timer_out_o);

  partition_partner i_partner (.clk_i, .arm_i(full_perimeter_arm_mode_o),
    .disarm_i(disarm_o), .disarm_ok_i(disarm_ok_o), .beep_i(beep_o), .armed_o(armed_i),
    .beeps_o());

  // Clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Timer due lines see fresh random values every cycle
  always @(posedge clk_i) begin
    rnd <= lfsr(rnd);
    timer_due_i <= rnd[19:0];
  end

  // Observed events, one bit per kind; edges only for level outputs
  assign ev = {ack_o & ~we_i, relay_o & ~rel_d, close_report_o, missed_close_o, code_ok_o,
               schedule_reject_message_o, beep_o, disarm_o & ~dis_d, disarm_ok_o,
               full_perimeter_arm_mode_o & bypass_faults_o,
               full_perimeter_arm_mode_o & ~bypass_faults_o};

  task automatic expect_ev(input int k, input int g, input int t, input logic [31:0] d);
    notes.push_back('{k, g, t, d});
  endtask

  // Oldest note against each event; gap is cycles since the last event or mark
  task automatic check_ev(input int k);
    note_t n;
    int d;
    d = cyc - mark;
    mark = cyc;
    checked++;
    if (notes.size() == 0) begin
      err_total++;
      $display("[ERR] event expected none seen %0d", k);
    end else begin
      n = notes.pop_front();
      if (n.kind != k || (n.gap >= 0 && (d < n.gap - n.tol || d > n.gap + n.tol))
          || (k == 10 && n.data !== dat_o)) begin
        err_total++;
        $display("[ERR] event expected %0d/%0d/%h seen %0d/%0d/%h", n.kind, n.gap, n.data,
                 k, d, dat_o);
      end
    end
  endtask

  // Monitor samples at the edge, before that edge's updates land
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rel_d <= relay_o;
    dis_d <= disarm_o;
    due_d <= timer_due_i;
    seen1 <= tm_chk & (seen1 | due_d[0]);
    // Timers follow their due lines; the one-shot bit fires at most once
    if (tm_chk === 1'b1 && rst_i === 1'b0) begin
      checked++;
      if (timer_out_o[19:1] !== due_d[19:1] || !(timer_out_o[0] === 1'b0 ||
          (timer_out_o[0] === 1'b1 && due_d[0] && !seen1))) begin
        err_total++;
        $display("[ERR] timer_out expected %h seen %h", due_d, timer_out_o);
      end
    end
    if (rst_i === 1'b0) begin
      for (int k = 0; k < 11; k++) begin
        if (ev[k] === 1'b1) check_ev(k);
      end
    end
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("[ERR] ack expected 1 seen timeout");
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expect_ev(10, -1, 0, e);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic rst_pulse();
    rst_i <= 1'b1;
    tk(3);
    rst_i <= 1'b0;
    tk(2);
  endtask

  task automatic dreq();
    disarm_req_i <= 1'b1;
    tk(1);
    disarm_req_i <= 1'b0;
    tk(6);
  endtask

  task automatic creq();
    code_req_i <= 1'b1;
    tk(1);
    code_req_i <= 1'b0;
    tk(6);
  endtask

  task automatic results();
    if (notes.size() != 0) begin
      err_total++;
      $display("[ERR] pending expected 0 seen %0d", notes.size());
    end
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 8.3k cycles the sequence needs
  initial begin
    tk(40000);
    err_total++;
    $display("[ERR] run expected done seen hang");
    results();
  end

  // Main sequence
  initial begin
    {cyc_i, stb_i, we_i, open_win_i, close_win_i, in_alarm_i, faults_i} = '0;
    {ext_req_i, ext_two_i, disarm_req_i, code_req_i, code_sched_en_i, sched_holiday_i} = '0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    code_sched_i = 3'h0;
    win_active_i = 20'h0;
    rnd = 32'h3349;
    tm_chk = 1'b0;
    err_total = 0;
    checked = 0;
    cyc = 0;
    mark = 0;
    rst_i = 1'b1;
    tk(3);
    rst_i <= 1'b0;
    tk(2);
    // Register reset values, unmapped place, write and read back
    rd(sched_pkg::ADR_CTRL, sched_pkg::CTRL_RESET);
    rd(sched_pkg::ADR_DELAYS, sched_pkg::DELAYS_RESET);
    rd(8'h1c, 32'h0);
    wb(1'b1, sched_pkg::ADR_TIMERS, rnd);
    wb(1'b1, sched_pkg::ADR_CTRL, 32'h0000_03ff);
    rd(sched_pkg::ADR_CTRL, 32'h0000_03ff);
    // Relay modes 0..3, then pulse-both in once mode over two windows
    for (int m = 0; m < 5; m++) begin
      rst_pulse();
      wb(1'b1, sched_pkg::ADR_CTRL, (m == 4) ? 32'h380 : 32'(m) << 8);
      if (m == 1) expect_ev(9, 41, 3, 0);
      else expect_ev(9, 2, 2, 0);
      if (m >= 3) expect_ev(9, 40, 3, 0);
      mark = cyc;
      win_active_i[0] <= 1'b1;
      tk(40);
      win_active_i[0] <= 1'b0;
      tk(20);
      if (m == 4) begin
        win_active_i[0] <= 1'b1;
        tk(40);
        win_active_i[0] <= 1'b0;
        tk(20);
      end
    end
    // Restricted disarm with alarm override, then each permitted case
    wb(1'b1, sched_pkg::ADR_CTRL, 32'h18);
    dreq();
    expect_ev(2, -1, 0, 0);
    in_alarm_i <= 1'b1;
    dreq();
    in_alarm_i <= 1'b0;
    expect_ev(2, -1, 0, 0);
    open_win_i <= 1'b1;
    dreq();
    open_win_i <= 1'b0;
    expect_ev(2, -1, 0, 0);
    close_win_i <= 1'b1;
    dreq();
    close_win_i <= 1'b0;
    wb(1'b1, sched_pkg::ADR_CTRL, 32'h08);
    in_alarm_i <= 1'b1;
    dreq();
    in_alarm_i <= 1'b0;
    wb(1'b1, sched_pkg::ADR_CTRL, 32'h0);
    expect_ev(2, -1, 0, 0);
    dreq();
    // Access schedule 0 limits a code to its window
    wb(1'b1, sched_pkg::ADR_ACCESS, 32'h1);
    code_sched_en_i <= 1'b1;
    expect_ev(5, -1, 0, 0);
    creq();
    win_active_i[1] <= 1'b1;
    expect_ev(6, -1, 0, 0);
    creq();
    win_active_i[1] <= 1'b0;
    code_sched_en_i <= 1'b0;
    expect_ev(6, -1, 0, 0);
    creq();
    // Auto-arm, no grace, one-minute warning, force arm over a fault
    wb(1'b1, sched_pkg::ADR_CTRL, 32'h65);
    wb(1'b1, sched_pkg::ADR_DELAYS, 32'h100);
    faults_i <= 1'b1;
    close_win_i <= 1'b1;
    tk(10);
    expect_ev(7, 2, 2, 0);
    expect_ev(4, 20, 20, 0);
    for (int b = 0; b < 11; b++) expect_ev(4, 100, 0, 0);
    expect_ev(1, -1, 0, 0);
    expect_ev(8, -1, 0, 0);
    mark = cyc;
    close_win_i <= 1'b0;
    tk(700);
    checked++;
    if (alert_msg_o !== 1'b1) begin
      err_total++;
      $display("[ERR] alert_msg expected 1 seen %b", alert_msg_o);
    end
    tk(700);
    faults_i <= 1'b0;
    checked++;
    if (armed_i !== 1'b1) begin
      err_total++;
      $display("[ERR] armed expected 1 seen %b", armed_i);
    end
    // Auto-disarm at opening window end, no delay
    wb(1'b1, sched_pkg::ADR_CTRL, 32'h2);
    open_win_i <= 1'b1;
    tk(10);
    expect_ev(3, 2, 2, 0);
    mark = cyc;
    open_win_i <= 1'b0;
    tk(20);
    // All timers enabled, timer zero one-shot, against the random due lines
    wb(1'b1, sched_pkg::ADR_TIMERS, 32'h000f_ffff);
    wb(1'b1, sched_pkg::ADR_RELAY, 32'h0000_0001);
    tm_chk = 1'b1;
    tk(60);
    tm_chk = 1'b0;
    // Two-hour extension, 4-minute grace, 2-minute warning, reset mid-warning
    wb(1'b1, sched_pkg::ADR_CTRL, 32'h1);
    wb(1'b1, sched_pkg::ADR_DELAYS, 32'h201);
    close_win_i <= 1'b1;
    ext_two_i <= 1'b1;
    tk(5);
    ext_req_i <= 1'b1;
    tk(1);
    ext_req_i <= 1'b0;
    tk(5);
    expect_ev(4, 5220, 25, 0);
    expect_ev(4, 300, 0, 0);
    expect_ev(4, 300, 0, 0);
    mark = cyc;
    close_win_i <= 1'b0;
    tk(5880);
    rst_pulse();
    tk(400);
    results();
  end
endmodule // partition_auto_arm_scheduler_tb
`default_nettype wire
